/* File: logic/sacf_params.svh */
// Purpose: Constants for the serial converter frame logic
// Assumes: 40 MHz system clock
// Notes: Counts derive from the times and the clock period

`ifndef SACF_PARAMS_SVH
`define SACF_PARAMS_SVH

// ----------------------------------------
// Clock and intervals
// ----------------------------------------
`define SACF_CLK_NS 25
`define SACF_ACQ_NS 350
`define SACF_ACQ_CYC ((`SACF_ACQ_NS + `SACF_CLK_NS - 1) / `SACF_CLK_NS)
`define SACF_QUIET_NS 50
`define SACF_QUIET_CYC ((`SACF_QUIET_NS + `SACF_CLK_NS - 1) / `SACF_CLK_NS)

// ----------------------------------------
// Frame layout
// ----------------------------------------
`define SACF_TRACK_RISE 13
`define SACF_RELEASE_FALL 16
`define SACF_LEAD_ZEROS 3
`define SACF_DATA_W 12
`define SACF_FRAME_BITS 16
`define SACF_CNT_W 5
`define SACF_BUF_DEPTH 2

`endif

/* File: logic/sacf_pkg.sv */
// Purpose: Types for the serial converter frame logic
// Assumes: Nothing beyond the parameter header
// Notes: Phase codes follow a Gray path through one frame

package sacf_pkg;

  // ----------------------------------------
  // Frame phase
  // ----------------------------------------
  typedef enum logic [1:0] {
    SACF_IDLE = 2'b00,
    SACF_HOLD = 2'b01,
    SACF_TAIL = 2'b11,
    SACF_DONE = 2'b10
  } sacf_phase_e;

endpackage

/* File: logic/sacf_buf_if.sv */
// Purpose: Valid/ready carrier between frame logic and its sample buffer
// Assumes: One clock domain
// Notes: Store side is the buffer, user side is the frame logic

`timescale 1ns/1ps

interface sacf_buf_if #(
  parameter int W = 12
);
  logic in_valid;
  logic in_ready;
  logic [W-1:0] in_data;
  logic out_valid;
  logic out_ready;
  logic [W-1:0] out_data;

  modport store (
    input in_valid,
    input in_data,
    input out_ready,
    output in_ready,
    output out_valid,
    output out_data
  );

  modport user (
    output in_valid,
    output in_data,
    output out_ready,
    input in_ready,
    input out_valid,
    input out_data
  );
endinterface

/* File: logic/sacf_buf.sv */
// Purpose: Two-entry sample buffer with valid and ready on both sides
// Assumes: Push and pop on the same clock
// Notes: Ready toward the source is registered so it can leave the top directly

`timescale 1ns/1ps
`include "sacf_params.svh"

module sacf_buf #(
  parameter int W = 12,
  parameter int DEPTH = `SACF_BUF_DEPTH
) (
  // Clock and reset
  input wire logic clk_i,
  input wire logic rst_n_i,
  // Buffer ports
  sacf_buf_if.store bus
);

  generate
    if (DEPTH != 2) begin : g_chk
      $error("sacf_buf supports exactly two entries");
    end
  endgenerate

  logic [W-1:0] mem_r [DEPTH];
  logic wr_ptr_r;
  logic rd_ptr_r;
  logic [1:0] cnt_r;
  logic [1:0] cnt_nxt;
  logic in_ready_r;
  logic push;
  logic pop;

  assign push = bus.in_valid & in_ready_r;
  assign pop = bus.out_ready & (cnt_r != 2'h0);
  assign bus.in_ready = in_ready_r;
  assign bus.out_valid = (cnt_r != 2'h0);
  assign bus.out_data = mem_r[rd_ptr_r];

  always_comb begin
    cnt_nxt = cnt_r;
    if (push && !pop) begin
      cnt_nxt = cnt_r + 2'h1;
    end else if (pop && !push) begin
      cnt_nxt = cnt_r - 2'h1;
    end
  end

  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      cnt_r <= 2'h0;
      in_ready_r <= 1'b1;
    end else begin
      cnt_r <= cnt_nxt;
      in_ready_r <= (cnt_nxt != 2'h2);
    end
  end

  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      wr_ptr_r <= 1'b0;
      rd_ptr_r <= 1'b0;
    end else begin
      if (push) begin
        wr_ptr_r <= ~wr_ptr_r;
      end
      if (pop) begin
        rd_ptr_r <= ~rd_ptr_r;
      end
    end
  end

  // Storage has no reset; a word is only read after it was written
  always_ff @(posedge clk_i) begin
    if (push) begin
      mem_r[wr_ptr_r] <= bus.in_data;
    end
  end

endmodule

/* File: logic/sacf_frame.sv */
// Purpose: Conversion framing and serial result output of a 12-bit converter
// Assumes: Frame select and serial clock are pins, sampled at 40 MHz
// Notes: Samples arrive as digital words through a two-entry buffer
//
// Operation
// - Frame select falling captures the sample and enters holding.
// - Thirteenth serial clock rise ends holding and returns to tracking.
// - Sixteenth serial clock fall ends conversion and releases the output.
// - Frame select falling starts driving the serial output.
// - Each new bit changes after a serial clock fall.
// - Three leading zeros, then twelve result bits, most significant first.
// - Result is plain binary, unchanged.

`timescale 1ns/1ps
`include "sacf_params.svh"

module sacf_frame #(
  parameter int DATA_W = `SACF_DATA_W,
  parameter int LEAD_ZEROS = `SACF_LEAD_ZEROS
) (
  // Clock and reset
  input wire logic clk_i,
  input wire logic rst_n_i,
  // Serial link pins
  input wire logic frame_sel_n_i,
  input wire logic sclk_i,
  output logic serial_result_out_o,
  output logic serial_result_oe_o,
  // Sample source
  input wire logic [DATA_W-1:0] sample_i,
  input wire logic sample_valid_i,
  output logic sample_ready_o,
  // Status
  output logic holding_o,
  output logic acq_err_o,
  output logic quiet_err_o
);

  // ----------------------------------------
  // Elaboration checks
  // ----------------------------------------
  localparam int FB = `SACF_FRAME_BITS;
  localparam int PAD = FB - LEAD_ZEROS - DATA_W;

  generate
    if (PAD < 1) begin : g_chk
      $error("sacf_frame: zeros plus data must leave one pad bit in the frame");
    end
  endgenerate

  localparam logic [`SACF_CNT_W-1:0] RISE_LAST = `SACF_CNT_W'(`SACF_TRACK_RISE - 1);
  localparam logic [`SACF_CNT_W-1:0] FALL_LAST = `SACF_CNT_W'(`SACF_RELEASE_FALL - 1);
  localparam logic [`SACF_CNT_W-1:0] CNT_MAX = {`SACF_CNT_W{1'b1}};
  localparam logic [4:0] ACQ_CYC = 5'(`SACF_ACQ_CYC);
  localparam logic [4:0] QUIET_CYC = 5'(`SACF_QUIET_CYC);

  // ----------------------------------------
  // Pin synchronisers and edges
  // ----------------------------------------
  logic cs_m_r, cs_s_r, cs_d_r;
  logic ck_m_r, ck_s_r, ck_d_r;
  logic cs_fall, cs_rise, rise_evt, fall_evt;

  // Select idles high and the bit clock low, so reset leaves no false edge
  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      cs_m_r <= 1'b1;
      cs_s_r <= 1'b1;
      cs_d_r <= 1'b1;
      ck_m_r <= 1'b0;
      ck_s_r <= 1'b0;
      ck_d_r <= 1'b0;
    end else begin
      cs_m_r <= frame_sel_n_i;
      cs_s_r <= cs_m_r;
      cs_d_r <= cs_s_r;
      ck_m_r <= sclk_i;
      ck_s_r <= ck_m_r;
      ck_d_r <= ck_s_r;
    end
  end

  assign cs_fall = cs_d_r & ~cs_s_r;
  assign cs_rise = ~cs_d_r & cs_s_r;
  assign rise_evt = ~ck_d_r & ck_s_r & ~cs_s_r;
  assign fall_evt = ck_d_r & ~ck_s_r & ~cs_s_r;

  // ----------------------------------------
  // Sample buffer
  // ----------------------------------------
  sacf_buf_if #(.W(DATA_W)) buf_bus ();

  assign buf_bus.in_valid = sample_valid_i;
  assign buf_bus.in_data = sample_i;
  assign buf_bus.out_ready = cs_fall;
  assign sample_ready_o = buf_bus.in_ready;

  sacf_buf #(
    .W(DATA_W),
    .DEPTH(`SACF_BUF_DEPTH)
  ) u_buf (
    .clk_i(clk_i),
    .rst_n_i(rst_n_i),
    .bus(buf_bus.store)
  );

  // ----------------------------------------
  // Edge counters
  // ----------------------------------------
  logic [`SACF_CNT_W-1:0] rise_cnt_r;
  logic [`SACF_CNT_W-1:0] fall_cnt_r;

  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      rise_cnt_r <= '0;
      fall_cnt_r <= '0;
    end else if (cs_fall) begin
      rise_cnt_r <= '0;
      fall_cnt_r <= '0;
    end else begin
      if (rise_evt && rise_cnt_r != CNT_MAX) begin
        rise_cnt_r <= rise_cnt_r + `SACF_CNT_W'(1);
      end
      if (fall_evt && fall_cnt_r != CNT_MAX) begin
        fall_cnt_r <= fall_cnt_r + `SACF_CNT_W'(1);
      end
    end
  end

  // ----------------------------------------
  // Frame phase
  // ----------------------------------------
  sacf_pkg::sacf_phase_e phase_r, phase_nxt;
  logic hold_r, oe_r;

  always_comb begin
    phase_nxt = phase_r;
    if (cs_fall) begin
      phase_nxt = sacf_pkg::SACF_HOLD;
    end else if (cs_rise) begin
      phase_nxt = sacf_pkg::SACF_IDLE;
    end else begin
      unique case (phase_r)
        sacf_pkg::SACF_IDLE: phase_nxt = sacf_pkg::SACF_IDLE;
        sacf_pkg::SACF_HOLD: begin
          if (rise_evt && rise_cnt_r == RISE_LAST) begin
            phase_nxt = sacf_pkg::SACF_TAIL;
          end
        end
        sacf_pkg::SACF_TAIL: begin
          if (fall_evt && fall_cnt_r == FALL_LAST) begin
            phase_nxt = sacf_pkg::SACF_DONE;
          end
        end
        sacf_pkg::SACF_DONE: phase_nxt = sacf_pkg::SACF_DONE;
      endcase
    end
  end

  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      phase_r <= sacf_pkg::SACF_IDLE;
      hold_r <= 1'b0;
      oe_r <= 1'b0;
    end else begin
      phase_r <= phase_nxt;
      hold_r <= (phase_nxt == sacf_pkg::SACF_HOLD);
      oe_r <= (phase_nxt == sacf_pkg::SACF_HOLD) || (phase_nxt == sacf_pkg::SACF_TAIL);
    end
  end

  // ----------------------------------------
  // Result shifter
  // ----------------------------------------
  logic [DATA_W-1:0] word_r;
  logic [FB-1:0] shift_r;
  logic dout_r;
  logic [DATA_W-1:0] word_now;

  // An empty buffer repeats the last word rather than shifting garbage
  assign word_now = buf_bus.out_valid ? buf_bus.out_data : word_r;

  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      word_r <= '0;
      shift_r <= '0;
      dout_r <= 1'b0;
    end else if (cs_fall) begin
      word_r <= word_now;
      shift_r <= {{LEAD_ZEROS{1'b0}}, word_now, {PAD{1'b0}}};
      dout_r <= 1'b0;
    end else if (fall_evt && phase_r != sacf_pkg::SACF_IDLE && fall_cnt_r < FALL_LAST) begin
      shift_r <= {shift_r[FB-2:0], 1'b0};
      dout_r <= shift_r[FB-2];
    end
  end

  // ----------------------------------------
  // Host interval checks
  // ----------------------------------------
  logic [4:0] acq_cnt_r, quiet_cnt_r;
  logic acq_err_r, quiet_err_r;

  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      acq_cnt_r <= ACQ_CYC;
      quiet_cnt_r <= QUIET_CYC;
      acq_err_r <= 1'b0;
      quiet_err_r <= 1'b0;
    end else begin
      if (hold_r) begin
        acq_cnt_r <= 5'h00;
      end else if (acq_cnt_r < ACQ_CYC) begin
        acq_cnt_r <= acq_cnt_r + 5'h01;
      end
      if (oe_r) begin
        quiet_cnt_r <= 5'h00;
      end else if (quiet_cnt_r < QUIET_CYC) begin
        quiet_cnt_r <= quiet_cnt_r + 5'h01;
      end
      acq_err_r <= cs_fall && (acq_cnt_r < ACQ_CYC);
      quiet_err_r <= cs_fall && (quiet_cnt_r < QUIET_CYC);
    end
  end

  assign serial_result_out_o = dout_r;
  assign serial_result_oe_o = oe_r;
  assign holding_o = hold_r;
  assign acq_err_o = acq_err_r;
  assign quiet_err_o = quiet_err_r;

  // ----------------------------------------
  // Assertions
  // ----------------------------------------
  property p_hold_on_start;
    @(posedge clk_i) disable iff (!rst_n_i) cs_fall |=> hold_r && phase_r == sacf_pkg::SACF_HOLD;
  endproperty
  a_hold_on_start: assert property (p_hold_on_start) else $error("no hold after frame start");

  property p_track_at_13;
    @(posedge clk_i) disable iff (!rst_n_i)
      (phase_r == sacf_pkg::SACF_HOLD && rise_evt && rise_cnt_r == 5'd12 && !cs_rise && !cs_fall) |=> !hold_r && oe_r;
  endproperty
  a_track_at_13: assert property (p_track_at_13) else $error("hold not left at 13th rise");

  property p_hold_before_13;
    @(posedge clk_i) disable iff (!rst_n_i) hold_r |-> rise_cnt_r < 5'd13;
  endproperty
  a_hold_before_13: assert property (p_hold_before_13) else $error("hold outlived 13th rise");

  property p_release_at_16;
    @(posedge clk_i) disable iff (!rst_n_i)
      (oe_r && fall_evt && fall_cnt_r == 5'd15 && !cs_fall) |=> !oe_r;
  endproperty
  a_release_at_16: assert property (p_release_at_16) else $error("output not released at 16th fall");

  property p_drive_on_start;
    @(posedge clk_i) disable iff (!rst_n_i) cs_fall |=> oe_r && !dout_r;
  endproperty
  a_drive_on_start: assert property (p_drive_on_start) else $error("output not driven at frame start");

  property p_bit_on_fall_only;
    @(posedge clk_i) disable iff (!rst_n_i) (!fall_evt && !cs_fall) |=> $stable(dout_r);
  endproperty
  a_bit_on_fall_only: assert property (p_bit_on_fall_only) else $error("bit changed without a fall");

  property p_lead_zeros;
    @(posedge clk_i) disable iff (!rst_n_i)
      (oe_r && fall_evt && fall_cnt_r < 5'd2 && !cs_fall) |=> !dout_r;
  endproperty
  a_lead_zeros: assert property (p_lead_zeros) else $error("leading bit not zero");

  property p_binary_load;
    @(posedge clk_i) disable iff (!rst_n_i)
      (cs_fall && buf_bus.out_valid) |=> word_r == $past(buf_bus.out_data) ##1 word_r == $past(word_r);
  endproperty
  a_binary_load: assert property (p_binary_load) else $error("captured word altered");

  property p_idle_released;
    @(posedge clk_i) disable iff (!rst_n_i) (cs_s_r && cs_d_r) |-> !oe_r;
  endproperty
  a_idle_released: assert property (p_idle_released) else $error("output driven while select high");

  property p_acq_flag;
    @(posedge clk_i) disable iff (!rst_n_i) (cs_fall && acq_cnt_r < 5'd14) |=> acq_err_r;
  endproperty
  a_acq_flag: assert property (p_acq_flag) else $error("short acquisition not flagged");

endmodule

/* File: verif/sacf_host.sv */
// Purpose: Host serial master model driving frame select and bit clock
// Assumes: Bit clock period 200 ns, unrelated to the system clock
// Notes: Bit clock stands still outside frames

`timescale 1ns/1ps

module sacf_host (
  // Link pins
  output logic frame_sel_n_o,
  output logic sclk_o,
  input wire logic serial_result_out_i,
  input wire logic serial_result_oe_i,
  // Observed status
  input wire logic holding_i
);
  localparam int HALF_NS = 100;
  logic last_bit;
  logic awake;

  // ----------------------------------------
  // Power-up
  // ----------------------------------------
  initial begin
    frame_sel_n_o = 1'b1;
    sclk_o = 1'b0;
    last_bit = 1'b0;
    awake = 1'b0;
    #1500;
    awake = 1'b1;
  end

  // ----------------------------------------
  // Frame
  // ----------------------------------------
  // Released line has no pull, so read it as the inverse of the last bit
  task automatic frame(input int nf, input int tail_ns, input int gap_ns,
                       output logic [15:0] cap, output logic [5:0] snap);
    logic b;
    cap = '0;
    snap = '0;
    wait (awake);
    frame_sel_n_o = 1'b0;
    #(HALF_NS + 50);
    snap[5] = serial_result_oe_i;
    snap[4] = holding_i;
    for (int i = 1; i <= nf && i <= 16; i++) begin
      if (i == 13) snap[3] = holding_i;
      if (i == 14) snap[2] = holding_i;
      sclk_o = 1'b1;
      #HALF_NS;
      b = (serial_result_oe_i === 1'b1) ? serial_result_out_i : ~last_bit;
      last_bit = b;
      cap = {cap[14:0], b};
      sclk_o = 1'b0;
      if (i < nf) #HALF_NS;
    end
    #(tail_ns);
    snap[1] = serial_result_oe_i;
    frame_sel_n_o = 1'b1;
    #(gap_ns);
    snap[0] = serial_result_oe_i;
  endtask
endmodule

/* File: verif/sacf_frame_tb.sv */
// Purpose: Self-checking bench for the converter frame logic
// Assumes: 40 MHz clock, host model on the link pins
// Notes: Buffer is filled until it refuses, then drained by frames

`timescale 1ns/1ps

module sacf_frame_tb;
  logic clk_i = 1'b0;
  logic rst_n_i;
  logic frame_sel_n;
  logic sclk;
  logic [11:0] sample_i;
  logic sample_valid_i;
  logic serial_result_out_o;
  logic serial_result_oe_o;
  logic sample_ready_o;
  logic holding_o;
  logic acq_err_o;
  logic quiet_err_o;
  int miscompares;
  int n_tests;
  int cycles;
  int acq_n;
  int quiet_n;
  logic [15:0] cap;
  logic [5:0] snap;
  logic [11:0] d1;
  logic [11:0] d2;
  logic [11:0] corner [4] = '{12'h000, 12'hfff, 12'h800, 12'h001};

  sacf_frame sacf_frame_inst (
    .clk_i(clk_i),
    .rst_n_i(rst_n_i),
    .frame_sel_n_i(frame_sel_n),
    .sclk_i(sclk),
    .serial_result_out_o(serial_result_out_o),
    .serial_result_oe_o(serial_result_oe_o),
    .sample_i(sample_i),
    .sample_valid_i(sample_valid_i),
    .sample_ready_o(sample_ready_o),
    .holding_o(holding_o),
    .acq_err_o(acq_err_o),
    .quiet_err_o(quiet_err_o)
  );

  sacf_host sacf_host_inst (
    .frame_sel_n_o(frame_sel_n),
    .sclk_o(sclk),
    .serial_result_out_i(serial_result_out_o),
    .serial_result_oe_i(serial_result_oe_o),
    .holding_i(holding_o)
  );

  // ----------------------------------------
  // Clock, timeout and pulse counters
  // ----------------------------------------
  always #12.5 clk_i = ~clk_i;

  always @(posedge clk_i) begin
    cycles++;
    if (acq_err_o === 1'b1) acq_n++;
    if (quiet_err_o === 1'b1) quiet_n++;
    if (cycles == 20000) begin
      miscompares++;
      test_done();
    end
  end

  // ----------------------------------------
  // Tasks
  // ----------------------------------------
  task automatic test_done();
    if (miscompares == 0 && n_tests > 0) $display("Test passed");
    else $display("Test failed");
    $finish;
  endtask

  task automatic check(input string name, input logic [15:0] seen, input logic [15:0] exp);
    n_tests++;
    if (seen !== exp) begin
      miscompares++;
      $display("[FAIL] %s expected %h seen %h", name, exp, seen);
    end
  endtask

  task automatic push(input logic [11:0] d);
    @(negedge clk_i);
    sample_i = d;
    sample_valid_i = 1'b1;
    for (int n = 0; n < 200 && sample_ready_o !== 1'b1; n++) @(negedge clk_i);
    @(negedge clk_i);
    sample_valid_i = 1'b0;
  endtask

  // Expected wire bits: three zeros, word MSB first, pad zero
  function automatic logic [15:0] exp_bits(input logic [11:0] d, input int nf);
    return {3'b000, d, 1'b0} >> (16 - nf);
  endfunction

  task automatic run_frame(input logic [11:0] d, input int nf, input int tail, input int gap);
    sacf_host_inst.frame(nf, tail, gap, cap, snap);
    check("frame bits", cap, exp_bits(d, nf));
    check("oe at start", snap[5], 1'b1);
    check("hold at start", snap[4], 1'b1);
    if (nf >= 13) check("hold before 13th rise", snap[3], 1'b1);
    if (nf >= 14) check("hold after 13th rise", snap[2], 1'b0);
    if (nf == 16 && tail >= 100) check("oe after 16th fall", snap[1], 1'b0);
    else if (nf < 16) check("oe before 16th fall", snap[1], 1'b1);
    if (gap >= 200) check("oe while select high", snap[0], 1'b0);
  endtask

  // ----------------------------------------
  // Main sequence
  // ----------------------------------------
  initial begin
    rst_n_i = 1'b0;
    sample_i = '0;
    sample_valid_i = 1'b0;
    void'($urandom(32'ha998e458));
    repeat (20) @(negedge clk_i);
    rst_n_i = 1'b1;
    check("ready after reset", sample_ready_o, 1'b1);
    // Fill until refused; a word offered while full must be dropped
    d1 = 12'($urandom);
    d2 = 12'($urandom);
    push(d1);
    push(d2);
    repeat (2) @(negedge clk_i);
    check("ready when full", sample_ready_o, 1'b0);
    sample_i = ~d2;
    sample_valid_i = 1'b1;
    repeat (6) @(negedge clk_i);
    sample_valid_i = 1'b0;
    run_frame(d1, 16, 150, 400);
    run_frame(d2, 16, 150, 400);
    run_frame(d2, 16, 150, 400);
    // Corner codes, then random words with random gaps
    for (int k = 0; k < 4; k++) begin
      push(corner[k]);
      run_frame(corner[k], 16, 150, 400);
    end
    for (int k = 0; k < 8; k++) begin
      d1 = 12'($urandom);
      push(d1);
      run_frame(d1, 16, 150, 400 + $urandom_range(0, 200));
    end
    // Abort mid-frame, then a full frame restarts cleanly
    d1 = 12'($urandom);
    d2 = 12'($urandom);
    push(d1);
    run_frame(d1, 5, 150, 400);
    push(d2);
    run_frame(d2, 16, 150, 400);
    // Short acquisition gap right after the 13th rise
    push(d1);
    push(d2);
    run_frame(d1, 13, 30, 100);
    run_frame(d2, 16, 150, 400);
    // Select raised at the 16th fall and lowered again inside the quiet interval
    push(d1);
    push(d2);
    run_frame(d1, 16, 0, 40);
    run_frame(d2, 16, 150, 400);
    check("acquisition errors", 16'(acq_n), 16'd1);
    check("quiet errors", 16'(quiet_n), 16'd1);
    test_done();
  end
endmodule
